// ### hfsr_pkg.sv
// Shared constants and types for the host FIFO status register bank.
`default_nettype none
package hfsr_pkg;
    localparam int unsigned ADDR_W   = 8;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned STRB_W   = 4;
    localparam int unsigned CNT_W    = 16;
    localparam int unsigned STAT_W   = 8;
    localparam int unsigned SKIP_W   = 14;
    localparam int unsigned CNT_LSB  = 0;
    localparam int unsigned STAT_LSB = 16;
    localparam int unsigned SKIP_BIT = 31;
    localparam int unsigned EV_SKIP_BIT = 0;
    localparam int unsigned EV_HALF_BIT = 23;

    localparam logic [ADDR_W-1:0] OFS_RX_PATH_CTL = 8'h78;
    localparam logic [ADDR_W-1:0] OFS_RX_OCC      = 8'h7c;
    localparam logic [ADDR_W-1:0] OFS_TX_OCC      = 8'h80;
    localparam logic [ADDR_W-1:0] OFS_DROP_CNT    = 8'ha0;
    localparam logic [ADDR_W-1:0] OFS_EV_STAT     = 8'hb0;
    localparam logic [ADDR_W-1:0] OFS_EV_MASK     = 8'hb4;

    localparam logic [DATA_W-1:0] EV_ALL       = 32'h0080_0001;
    localparam logic [DATA_W-1:0] DROP_RESET   = 32'h0000_0000;
    localparam logic [DATA_W-1:0] DROP_HALF    = 32'h7fff_ffff;
    localparam logic [DATA_W-1:0] DROP_ONE     = 32'h0000_0001;
    localparam logic [CNT_W-1:0]  TX_FREE_RESET = 16'h1200;
    localparam logic [CNT_W-1:0]  WORD_BYTES   = 16'h0004;
    localparam logic [CNT_W-1:0]  ROUND_ADD    = 16'h0003;
    localparam logic [CNT_W-1:0]  ALIGN_MASK   = 16'hfffc;
    localparam logic [STAT_W-1:0] STAT_ONE     = 8'h01;
    localparam logic [SKIP_W-1:0] SKIP_ONE     = 14'h0001;
    localparam logic [1:0]        RESP_OKAY    = 2'h0;
    localparam logic [1:0]        RESP_SLVERR  = 2'h2;

    typedef enum logic [1:0]
    {
        SKIP_IDLE = 2'h0,
        SKIP_RUN  = 2'h1,
        SKIP_DONE = 2'h3
    } hfsr_skip_state_t;
endpackage
`default_nettype wire

// ### hfsr_skip_engine.sv
// Frame skip engine that pops the rest of the current receive frame.
`timescale 1ns/1ps
`default_nettype none
module hfsr_skip_engine
(
    input  wire logic aclk,
    input  wire logic aresetn,
    hfsr_skip_if.eng  sk
);
    hfsr_pkg::hfsr_skip_state_t  state_ff;
    hfsr_pkg::hfsr_skip_state_t  nxt_state;
    logic [hfsr_pkg::SKIP_W-1:0] left_ff;
    logic [hfsr_pkg::SKIP_W-1:0] nxt_left;

    assign sk.pop  = (state_ff == hfsr_pkg::SKIP_RUN);
    assign sk.done = (state_ff == hfsr_pkg::SKIP_DONE);
    assign sk.busy = (state_ff != hfsr_pkg::SKIP_IDLE);

    always_comb
    begin
        nxt_state = state_ff;
        nxt_left  = left_ff;
        case (state_ff)
            hfsr_pkg::SKIP_IDLE:
            begin
                if (sk.start)
                begin
                    nxt_left = sk.words_left;
                    if (sk.words_left == '0)
                        nxt_state = hfsr_pkg::SKIP_DONE;
                    else
                        nxt_state = hfsr_pkg::SKIP_RUN;
                end
            end
            hfsr_pkg::SKIP_RUN:
            begin
                nxt_left = left_ff - hfsr_pkg::SKIP_ONE;
                if (left_ff == hfsr_pkg::SKIP_ONE)
                    nxt_state = hfsr_pkg::SKIP_DONE;
            end
            default:
                nxt_state = hfsr_pkg::SKIP_IDLE;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_ff <= hfsr_pkg::SKIP_IDLE;
            left_ff  <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            left_ff  <= nxt_left;
        end
    end

    a_skip_last_word: assert property (
        @(posedge aclk) disable iff (!aresetn)
        state_ff == hfsr_pkg::SKIP_RUN && left_ff == hfsr_pkg::SKIP_ONE
        |=> sk.done ##1 !sk.busy)
        else $error("Skip did not end after the last word.");

    a_skip_empty_frame: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !sk.busy && sk.start && sk.words_left == '0
        |=> sk.busy && !sk.pop ##1 !sk.busy)
        else $error("Empty skip did not finish in one cycle.");

    a_skip_busy_hold: assert property (
        @(posedge aclk) disable iff (!aresetn)
        sk.pop |=> sk.busy)
        else $error("Skip dropped busy before done.");
endmodule
`default_nettype wire

// ### hfsr_skip_if.sv
// Handshake between the register bank and the frame skip engine.
`timescale 1ns/1ps
`default_nettype none
interface hfsr_skip_if;
    logic                        start;
    logic [hfsr_pkg::SKIP_W-1:0] words_left;
    logic                        pop;
    logic                        busy;
    logic                        done;

    modport eng (input start, input words_left,
                 output pop, output busy, output done);
    modport ctl (output start, output words_left,
                 input pop, input busy, input done);
endinterface
`default_nettype wire

// ### hfsr_top.sv
// Host FIFO status register bank with AXI4-Lite slave and event interrupt.
// Summary of operation
// - A one written to the frame skip bit pops the rest of the frame.
// - The skip bit reads one until the skip has ended, then clears itself.
// - Receive status words used is a read-only count, zero after reset.
// - Receive data bytes used grows by each stored frame, zero at reset.
// - A frame length that is not whole words is rounded up to a word.
// - Transmit status words used is a read-only count, zero after reset.
// - Transmit data bytes free reads the full empty capacity after reset.
// - Each dropped receive frame steps the 32-bit tally up by one.
// - Any read of the tally returns its value and then clears it.
// - The tally passing its midpoint raises the half-way event.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module hfsr_top
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        rx_frame_stored,
    input  wire logic [15:0] rx_frame_len,
    input  wire logic        rx_data_word_pop,
    input  wire logic [13:0] rx_cur_words_left,
    output logic             rx_skip_pop,
    input  wire logic        rx_status_push,
    input  wire logic        rx_status_pop,
    input  wire logic        tx_status_push,
    input  wire logic        tx_status_pop,
    input  wire logic        tx_data_word_push,
    input  wire logic        tx_data_word_drain,
    input  wire logic        rx_frame_dropped,
    output logic             irq
);
    hfsr_skip_if sk ();

    logic        aw_held_ff;
    logic        nxt_aw_held;
    logic [7:0]  awaddr_ff;
    logic [7:0]  nxt_awaddr;
    logic        w_held_ff;
    logic        nxt_w_held;
    logic [31:0] wdata_ff;
    logic [31:0] nxt_wdata;
    logic [3:0]  wstrb_ff;
    logic [3:0]  nxt_wstrb;
    logic        bvalid_ff;
    logic        nxt_bvalid;
    logic [1:0]  bresp_ff;
    logic [1:0]  nxt_bresp;
    logic        rvalid_ff;
    logic        nxt_rvalid;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [1:0]  rresp_ff;
    logic [1:0]  nxt_rresp;
    logic        skip_go_ff;
    logic        nxt_skip_go;
    logic [31:0] mask_ff;
    logic [31:0] nxt_mask;
    logic [31:0] ev_ff;
    logic [31:0] nxt_ev;
    logic        irq_ff;
    logic        nxt_irq;
    logic [31:0] drop_cnt_ff;
    logic [31:0] nxt_drop_cnt;
    logic [7:0]  rx_sused_ff;
    logic [7:0]  nxt_rx_sused;
    logic [15:0] rx_dused_ff;
    logic [15:0] nxt_rx_dused;
    logic [7:0]  tx_sused_ff;
    logic [7:0]  nxt_tx_sused;
    logic [15:0] tx_free_ff;
    logic [15:0] nxt_tx_free;
    logic        aw_take;
    logic        w_take;
    logic        ar_take;
    logic        wr_commit;
    logic        wr_map;
    logic        rd_map;
    logic        rd_ev;
    logic        rd_drop;
    logic        half_cross;
    logic [31:0] rd_val;
    logic [31:0] wmask;
    logic [31:0] ev_set;
    logic [15:0] rx_add;
    logic [15:0] rx_sub;
    hfsr_skip_engine u_skip
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .sk      (sk)
    );

    assign sk.start      = skip_go_ff;
    assign sk.words_left = rx_cur_words_left;
    assign rx_skip_pop   = sk.pop;

    // A new request waits while the answer is pending, so each channel
    // holds at most one beat and no response can be overwritten.
    assign s_axi_awready = !aw_held_ff && !bvalid_ff;
    assign s_axi_wready  = !w_held_ff && !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;
    assign irq           = irq_ff;

    assign aw_take   = s_axi_awvalid && s_axi_awready;
    assign w_take    = s_axi_wvalid && s_axi_wready;
    assign ar_take   = s_axi_arvalid && s_axi_arready;
    assign wr_commit = aw_held_ff && w_held_ff;
    assign rd_ev     = ar_take && s_axi_araddr == hfsr_pkg::OFS_EV_STAT;
    assign rd_drop   = ar_take && s_axi_araddr == hfsr_pkg::OFS_DROP_CNT;

    genvar lane;
    generate
        for (lane = 0; lane < hfsr_pkg::STRB_W; lane++)
        begin : g_lane
            assign wmask[8*lane +: 8] = {8{wstrb_ff[lane]}};
        end
    endgenerate

    always_comb
    begin
        wr_map = 1'b0;
        if (awaddr_ff == hfsr_pkg::OFS_RX_PATH_CTL ||
            awaddr_ff == hfsr_pkg::OFS_RX_OCC ||
            awaddr_ff == hfsr_pkg::OFS_TX_OCC ||
            awaddr_ff == hfsr_pkg::OFS_DROP_CNT ||
            awaddr_ff == hfsr_pkg::OFS_EV_STAT ||
            awaddr_ff == hfsr_pkg::OFS_EV_MASK)
            wr_map = 1'b1;
    end

    always_comb
    begin
        rd_val = '0;
        rd_map = 1'b1;
        if (s_axi_araddr == hfsr_pkg::OFS_RX_PATH_CTL)
            rd_val[hfsr_pkg::SKIP_BIT] = skip_go_ff || sk.busy;
        else if (s_axi_araddr == hfsr_pkg::OFS_RX_OCC)
        begin
            rd_val[hfsr_pkg::STAT_LSB +: hfsr_pkg::STAT_W] = rx_sused_ff;
            rd_val[hfsr_pkg::CNT_LSB +: hfsr_pkg::CNT_W]   = rx_dused_ff;
        end
        else if (s_axi_araddr == hfsr_pkg::OFS_TX_OCC)
        begin
            rd_val[hfsr_pkg::STAT_LSB +: hfsr_pkg::STAT_W] = tx_sused_ff;
            rd_val[hfsr_pkg::CNT_LSB +: hfsr_pkg::CNT_W]   = tx_free_ff;
        end
        else if (s_axi_araddr == hfsr_pkg::OFS_DROP_CNT)
            rd_val = drop_cnt_ff;
        else if (s_axi_araddr == hfsr_pkg::OFS_EV_STAT)
            rd_val = ev_ff;
        else if (s_axi_araddr == hfsr_pkg::OFS_EV_MASK)
            rd_val = mask_ff;
        else
            rd_map = 1'b0;
    end

    always_comb
    begin
        nxt_aw_held = aw_held_ff;
        nxt_awaddr  = awaddr_ff;
        nxt_w_held  = w_held_ff;
        nxt_wdata   = wdata_ff;
        nxt_wstrb   = wstrb_ff;
        nxt_bvalid  = bvalid_ff;
        nxt_bresp   = bresp_ff;
        nxt_rvalid  = rvalid_ff;
        nxt_rdata   = rdata_ff;
        nxt_rresp   = rresp_ff;
        if (aw_take)
        begin
            nxt_aw_held = 1'b1;
            nxt_awaddr  = s_axi_awaddr;
        end
        if (w_take)
        begin
            nxt_w_held = 1'b1;
            nxt_wdata  = s_axi_wdata;
            nxt_wstrb  = s_axi_wstrb;
        end
        if (wr_commit)
        begin
            nxt_aw_held = 1'b0;
            nxt_w_held  = 1'b0;
            nxt_bvalid  = 1'b1;
            nxt_bresp   = wr_map ? hfsr_pkg::RESP_OKAY : hfsr_pkg::RESP_SLVERR;
        end
        else if (bvalid_ff && s_axi_bready)
            nxt_bvalid = 1'b0;
        if (ar_take)
        begin
            nxt_rvalid = 1'b1;
            nxt_rdata  = rd_val;
            nxt_rresp  = rd_map ? hfsr_pkg::RESP_OKAY : hfsr_pkg::RESP_SLVERR;
        end
        else if (rvalid_ff && s_axi_rready)
            nxt_rvalid = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_ff <= 1'b0;
            awaddr_ff  <= '0;
            w_held_ff  <= 1'b0;
            wdata_ff   <= '0;
            wstrb_ff   <= '0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= hfsr_pkg::RESP_OKAY;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= '0;
            rresp_ff   <= hfsr_pkg::RESP_OKAY;
        end
        else
        begin
            aw_held_ff <= nxt_aw_held;
            awaddr_ff  <= nxt_awaddr;
            w_held_ff  <= nxt_w_held;
            wdata_ff   <= nxt_wdata;
            wstrb_ff   <= nxt_wstrb;
            bvalid_ff  <= nxt_bvalid;
            bresp_ff   <= nxt_bresp;
            rvalid_ff  <= nxt_rvalid;
            rdata_ff   <= nxt_rdata;
            rresp_ff   <= nxt_rresp;
        end
    end

    assign half_cross = rx_frame_dropped && !rd_drop &&
                        drop_cnt_ff == hfsr_pkg::DROP_HALF;

    assign rx_add = rx_frame_stored ?
        ((rx_frame_len + hfsr_pkg::ROUND_ADD) & hfsr_pkg::ALIGN_MASK) : '0;
    // Host pops and skip pops never coincide when software keeps off the
    // data port during a skip, so one word is the most leaving per cycle.
    assign rx_sub = (rx_data_word_pop || sk.pop) ? hfsr_pkg::WORD_BYTES : '0;

    always_comb
    begin
        ev_set = '0;
        ev_set[hfsr_pkg::EV_HALF_BIT] = half_cross;
        ev_set[hfsr_pkg::EV_SKIP_BIT] = sk.done;
        nxt_skip_go = wr_commit && wdata_ff[hfsr_pkg::SKIP_BIT] &&
                      wmask[hfsr_pkg::SKIP_BIT] && !sk.busy && !skip_go_ff &&
                      awaddr_ff == hfsr_pkg::OFS_RX_PATH_CTL;
        nxt_mask = mask_ff;
        if (wr_commit && awaddr_ff == hfsr_pkg::OFS_EV_MASK)
            nxt_mask = ((wdata_ff & wmask) | (mask_ff & ~wmask)) &
                       hfsr_pkg::EV_ALL;
        // A new event in the cycle of the clearing read survives it.
        nxt_ev  = (rd_ev ? '0 : ev_ff) | ev_set;
        nxt_irq = |(nxt_ev & nxt_mask);
        nxt_drop_cnt = rd_drop ? hfsr_pkg::DROP_RESET : drop_cnt_ff;
        if (rx_frame_dropped)
            nxt_drop_cnt = nxt_drop_cnt + hfsr_pkg::DROP_ONE;
        nxt_rx_sused = rx_sused_ff +
                       (rx_status_push ? hfsr_pkg::STAT_ONE : '0) -
                       (rx_status_pop ? hfsr_pkg::STAT_ONE : '0);
        nxt_rx_dused = rx_dused_ff + rx_add - rx_sub;
        nxt_tx_sused = tx_sused_ff +
                       (tx_status_push ? hfsr_pkg::STAT_ONE : '0) -
                       (tx_status_pop ? hfsr_pkg::STAT_ONE : '0);
        nxt_tx_free = tx_free_ff +
                      (tx_data_word_drain ? hfsr_pkg::WORD_BYTES : '0) -
                      (tx_data_word_push ? hfsr_pkg::WORD_BYTES : '0);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            skip_go_ff  <= 1'b0;
            mask_ff     <= '0;
            ev_ff       <= '0;
            irq_ff      <= 1'b0;
            drop_cnt_ff <= hfsr_pkg::DROP_RESET;
            rx_sused_ff <= '0;
            rx_dused_ff <= '0;
            tx_sused_ff <= '0;
            tx_free_ff  <= hfsr_pkg::TX_FREE_RESET;
        end
        else
        begin
            skip_go_ff  <= nxt_skip_go;
            mask_ff     <= nxt_mask;
            ev_ff       <= nxt_ev;
            irq_ff      <= nxt_irq;
            drop_cnt_ff <= nxt_drop_cnt;
            rx_sused_ff <= nxt_rx_sused;
            rx_dused_ff <= nxt_rx_dused;
            tx_sused_ff <= nxt_tx_sused;
            tx_free_ff  <= nxt_tx_free;
        end
    end

    a_drop_step_one: assert property (
        @(posedge aclk) disable iff (!aresetn)
        rx_frame_dropped && !rd_drop
        |=> drop_cnt_ff == $past(drop_cnt_ff) + hfsr_pkg::DROP_ONE)
        else $error("Dropped frame tally did not step by one.");
    a_drop_read_clear: assert property (
        @(posedge aclk) disable iff (!aresetn)
        rd_drop && !rx_frame_dropped
        |=> drop_cnt_ff == '0 && s_axi_rdata == $past(drop_cnt_ff))
        else $error("Tally read did not return and clear the count.");
    a_half_event_set: assert property (
        @(posedge aclk) disable iff (!aresetn)
        half_cross |=> ev_ff[hfsr_pkg::EV_HALF_BIT] ##1
        (ev_ff[hfsr_pkg::EV_HALF_BIT] || $past(rd_ev)))
        else $error("Half-way event was not held.");
    a_skip_reads_one: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ar_take && s_axi_araddr == hfsr_pkg::OFS_RX_PATH_CTL && sk.busy
        |=> s_axi_rvalid && s_axi_rdata[hfsr_pkg::SKIP_BIT])
        else $error("Skip bit read zero during a skip.");
    a_rx_used_round: assert property (
        @(posedge aclk) disable iff (!aresetn)
        rx_frame_stored && !rx_data_word_pop && !sk.pop
        |=> rx_dused_ff == $past(rx_dused_ff) +
        (($past(rx_frame_len) + hfsr_pkg::ROUND_ADD) & hfsr_pkg::ALIGN_MASK))
        else $error("Receive data used did not add the rounded length.");
    a_rx_stat_used: assert property (
        @(posedge aclk) disable iff (!aresetn)
        rx_status_push && !rx_status_pop
        |=> rx_sused_ff == $past(rx_sused_ff) + hfsr_pkg::STAT_ONE)
        else $error("Receive status used did not count a push.");
    a_ctl_resv_zero: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ar_take && s_axi_araddr == hfsr_pkg::OFS_RX_PATH_CTL
        |=> s_axi_rdata[hfsr_pkg::SKIP_BIT-1:0] == '0)
        else $error("Reserved control bits read nonzero.");
endmodule
`default_nettype wire

// ### hfsr_top_tb.sv
// Self-checking testbench for the host FIFO status register bank.
`timescale 1ns/1ps
`default_nettype none
module hfsr_top_tb;
    logic        aclk, aresetn;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, skip_pop, irq;
    logic [15:0] frame_len;
    logic [13:0] words_left;
    logic [8:0]  dp;
    logic [31:0] v;
    logic [1:0]  r;
    int          fail_count, tests_run, pops;

    hfsr_top dut_u
    (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .rx_frame_stored(dp[0]), .rx_frame_len(frame_len),
        .rx_data_word_pop(dp[1]), .rx_cur_words_left(words_left),
        .rx_skip_pop(skip_pop), .rx_status_push(dp[2]),
        .rx_status_pop(dp[3]), .tx_status_push(dp[4]),
        .tx_status_pop(dp[5]), .tx_data_word_push(dp[6]),
        .tx_data_word_drain(dp[7]), .rx_frame_dropped(dp[8]), .irq(irq)
    );

    always #5 aclk = ~aclk;

    always @(posedge aclk)
        if (skip_pop === 1'b1)
            pops <= pops + 1;

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic timed_out();
        fail_count++;
        $display("unexpected at %0t: wait ran out", $time);
        end_of_test();
    endtask

    // Address and data are offered together; each drops once it is taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit aw_ok, w_ok, b_ok;
        int n;
        aw_ok = 0;
        w_ok = 0;
        b_ok = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 40 && !b_ok; n++)
        begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1)
            begin
                aw_ok = 1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready === 1'b1)
            begin
                w_ok = 1;
                wvalid <= 1'b0;
            end
            if (aw_ok && w_ok && bvalid === 1'b1)
            begin
                b_ok = 1;
                r = bresp;
                bready <= 1'b0;
            end
        end
        if (!b_ok)
            timed_out();
    endtask

    task automatic rd(input logic [7:0] a);
        bit a_ok, d_ok;
        int n;
        a_ok = 0;
        d_ok = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 40 && !d_ok; n++)
        begin
            @(posedge aclk);
            if (arvalid && arready === 1'b1)
            begin
                a_ok = 1;
                arvalid <= 1'b0;
            end
            if (a_ok && rvalid === 1'b1)
            begin
                d_ok = 1;
                v = rdata;
                r = rresp;
                rready <= 1'b0;
            end
        end
        if (!d_ok)
            timed_out();
    endtask

    task automatic pulse(input logic [8:0] m, input int count);
        repeat (count)
        begin
            @(posedge aclk);
            dp <= m;
            @(posedge aclk);
            dp <= 9'h000;
        end
    endtask

    // Polls the control register until the skip bit has dropped.
    task automatic wait_skip();
        int n;
        for (n = 0; n < 60; n++)
        begin
            rd(8'h78);
            if (v[31] === 1'b0)
                return;
        end
        timed_out();
    endtask

    task automatic t_reset();
        rd(8'h78); check(v, 32'h0000_0000);
        rd(8'h7c); check(v, 32'h0000_0000);
        rd(8'h80); check(v, 32'h0000_1200);
        rd(8'ha0); check(v, 32'h0000_0000);
        rd(8'hb0); check(v, 32'h0000_0000);
        $display("test reset values done");
    endtask

    task automatic t_rx_occupancy();
        frame_len <= 16'h0005;
        pulse(9'h001, 1);
        frame_len <= 16'h0062;
        pulse(9'h001, 1);
        pulse(9'h004, 2);
        pulse(9'h008, 1);
        pulse(9'h00c, 1);
        pulse(9'h002, 1);
        // Rounded lengths 8 and 100, less one popped word.
        rd(8'h7c); check(v, 32'h0001_0068);
        $display("test receive occupancy done");
    endtask

    task automatic t_tx_occupancy();
        pulse(9'h010, 2);
        pulse(9'h020, 1);
        pulse(9'h040, 3);
        pulse(9'h080, 1);
        rd(8'h80); check(v, 32'h0001_11f8);
        wr(8'h80, 32'hffff_ffff); check({30'h0, r}, 32'h0);
        rd(8'h80); check(v, 32'h0001_11f8);
        $display("test transmit occupancy done");
    endtask

    task automatic t_irq();
        words_left <= 14'h0000;
        wr(8'hb4, 32'h0000_0000);
        wr(8'h78, 32'h8000_0000);
        wait_skip();
        check({31'h0, irq}, 32'h0);
        wr(8'hb4, 32'hffff_ffff);
        rd(8'hb4); check(v, 32'h0080_0001);
        repeat (2) @(posedge aclk);
        check({31'h0, irq}, 32'h1);
        rd(8'hb0); check(v, 32'h0000_0001);
        repeat (2) @(posedge aclk);
        check({31'h0, irq}, 32'h0);
        rd(8'hb0); check(v, 32'h0000_0000);
        $display("test interrupt done");
    endtask

    task automatic t_skip();
        int p0;
        words_left <= 14'h0014;
        p0 = pops;
        wr(8'h78, 32'h8000_0000);
        rd(8'h78); check(v, 32'h8000_0000);
        wait_skip();
        check(pops - p0, 32'd20);
        rd(8'h7c); check(v, 32'h0001_0018);
        check({31'h0, irq}, 32'h1);
        rd(8'hb0); check(v, 32'h0000_0001);
        wr(8'h78, 32'h7fff_ffff);
        rd(8'h78); check(v, 32'h0000_0000);
        // Without its byte lane the skip bit must not start a skip.
        wstrb <= 4'h7;
        wr(8'h78, 32'h8000_0000);
        wstrb <= 4'hf;
        rd(8'h78); check(v, 32'h0000_0000);
        $display("test frame skip done");
    endtask

    task automatic t_tally();
        pulse(9'h100, 3);
        rd(8'ha0); check(v, 32'h0000_0003);
        rd(8'ha0); check(v, 32'h0000_0000);
        rd(8'h04); check({30'h0, r}, 32'h2);
        check(v, 32'h0000_0000);
        wr(8'h04, 32'h1234_5678); check({30'h0, r}, 32'h2);
        $display("test dropped tally done");
    endtask

    initial
    begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0000_0000;
        wstrb = 4'hf;
        frame_len = 16'h0000;
        words_left = 14'h0000;
        dp = 9'h000;
        pops = 0;
        fail_count = 0;
        tests_run = 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_rx_occupancy();
        t_tx_occupancy();
        t_irq();
        t_skip();
        t_tally();
        end_of_test();
    end
endmodule
`default_nettype wire
